/* design/bsc_params.svh */
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH
`define BSC_SR_SYSTEM_MODE_FLAG      15
`define BSC_SR_MASK_HI   14
`define BSC_SR_MASK_LO   12
`define BSC_SR_WIDE      11
`define BSC_SR_BANK_HI   10
`define BSC_SR_BANK_LO   8
`define BSC_SR_S         7
`define BSC_SR_Z         6
`define BSC_SR_H         4
`define BSC_SR_V         2
`define BSC_SR_N         1
`define BSC_SR_C         0
`define BSC_SR_RSVD_MASK 16'hFFD7
`define BSC_SR_RESET     16'hF000
`define BSC_MASK_ALL     3'h7
`define BSC_MASK_DEF     3'h0
`define BSC_TRAP_DEF     3'h7
`define BSC_TRAP_BASE    32'h0000_8000
`define BSC_TRAP_STEP    4
`define BSC_STAT_BYTES   32'h0000_0002
`define BSC_FRAME_MIN    32'h0000_0004
`define BSC_FRAME_MAX    32'h0000_0006
`define BSC_LATE_SLOTS   2'h1
`endif

/* design/bsc_pkg.sv */
package bsc_pkg;
    typedef enum logic [4:0] {
        BSC_IDLE  = 5'h00,
        BSC_ZCF   = 5'h01,
        BSC_TEST  = 5'h02,
        BSC_CLR   = 5'h03,
        BSC_SET   = 5'h04,
        BSC_INV   = 5'h05,
        BSC_TEST_AND_SET_OP  = 5'h06,
        BSC_SRCHB = 5'h07,
        BSC_SRCHF = 5'h08,
        BSC_NORM  = 5'h09,
        BSC_WIDE  = 5'h0A,
        BSC_EI    = 5'h0B,
        BSC_DI    = 5'h0C,
        BSC_PUSH  = 5'h0D,
        BSC_POP   = 5'h0E,
        BSC_TRAP  = 5'h0F,
        BSC_EXTI  = 5'h10
    } bsc_op_type;

    typedef struct packed {
        bsc_op_type  op;
        logic        mem_form;
        logic        has_imm;
        logic [3:0]  bit_num;
        logic [2:0]  imm3;
        logic [15:0] operand;
        logic [31:0] next_pc;
        logic [15:0] pop_word;
    } bsc_req_type;

    typedef struct packed {
        logic        done;
        logic        wr_en;
        logic [15:0] wr_data;
        logic        a_wr;
        logic [7:0]  a_data;
        logic        mem_wr;
        logic [31:0] mem_addr;
        logic [15:0] mem_data;
        logic        mem_wr2;
        logic [31:0] mem_addr2;
        logic [31:0] mem_data2;
        logic        jump;
        logic [31:0] jump_pc;
        logic        priv_fault;
    } bsc_rsp_type;

    typedef enum logic [1:0] {
        BSC_TRAP_SW   = 2'b00,
        BSC_TRAP_PRIV = 2'b01,
        BSC_TRAP_ILL  = 2'b10,
        BSC_TRAP_HW   = 2'b11
    } bsc_trap_type;
endpackage

/* design/bsc_core.sv */
`include "bsc_params.svh"

module bsc_core
    import bsc_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // Instruction request
    input  wire logic        req_valid_i,
    input  wire bsc_req_type req_i,
    input  wire bsc_trap_type trap_kind_i,
    input  wire logic [31:0] stack_ptr_i,
    // Results
    output bsc_rsp_type      rsp_o,
    output logic [31:0]      stack_ptr_o,
    output logic [15:0]      status_o,
    output logic             fetch_system_mode_flag_o
);
    logic [15:0] sr;
    logic [15:0] next_sr;
    logic [31:0] sp;
    logic [31:0] next_sp;
    logic        fetch_system_mode_flag;
    logic        next_fetch_system_mode_flag;
    bsc_rsp_type rsp;
    bsc_rsp_type next_rsp;

    logic [15:0] bitmask;
    logic        sel_bit;
    logic [3:0]  hi_pos;
    logic [3:0]  lo_pos;
    logic        src_zero;
    logic        privileged;
    logic        wide;
    logic [2:0]  bank_in;

    assign wide = sr[`BSC_SR_WIDE];
    // Memory form numbers bits of a byte only
    assign bitmask = req_i.mem_form ? (16'h0001 << req_i.bit_num[2:0])
                                    : (16'h0001 << req_i.bit_num);
    assign sel_bit = |(req_i.operand & bitmask);
    assign src_zero = (req_i.operand == 16'h0000);

    // Priority scans; one generate-free loop each way keeps them short
    always_comb begin
        hi_pos = 4'h0;
        lo_pos = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (req_i.operand[i]) begin
                hi_pos = 4'(i);
            end
        end
        for (int i = 15; i >= 0; i--) begin
            if (req_i.operand[i]) begin
                lo_pos = 4'(i);
            end
        end
    end

    always_comb begin
        unique case (req_i.op)
            BSC_NORM, BSC_WIDE, BSC_EI, BSC_DI, BSC_PUSH, BSC_POP:
                privileged = 1'b1;
            default:
                privileged = 1'b0;
        endcase
    end

    // Bank pointer of a restored word obeys the width flag it carries
    assign bank_in = {req_i.pop_word[`BSC_SR_BANK_HI] & ~req_i.pop_word[`BSC_SR_WIDE],
                      req_i.pop_word[`BSC_SR_BANK_HI-1:`BSC_SR_BANK_LO]};

    always_comb begin
        next_sr = sr;
        next_sp = sp;
        next_fetch_system_mode_flag = sr[`BSC_SR_SYSTEM_MODE_FLAG];
        next_rsp = '0;
        if (req_valid_i) begin
            next_sp = stack_ptr_i;
            next_rsp.done = 1'b1;
            if (privileged && !sr[`BSC_SR_SYSTEM_MODE_FLAG]) begin
                // Fault replaces the instruction; trap entry follows as BSC_EXTI
                next_rsp.priv_fault = 1'b1;
            end else begin
                unique case (req_i.op)
                    BSC_IDLE: begin
                        next_sr = sr;
                    end
                    BSC_ZCF: begin
                        next_sr[`BSC_SR_C] = ~sr[`BSC_SR_Z];
                        next_sr[`BSC_SR_N] = 1'b0;
                    end
                    BSC_TEST: begin
                        next_sr[`BSC_SR_Z] = ~sel_bit;
                        next_sr[`BSC_SR_H] = 1'b1;
                        next_sr[`BSC_SR_N] = 1'b0;
                    end
                    BSC_CLR: begin
                        next_rsp.wr_en = 1'b1;
                        next_rsp.wr_data = req_i.operand & ~bitmask;
                    end
                    BSC_SET: begin
                        next_rsp.wr_en = 1'b1;
                        next_rsp.wr_data = req_i.operand | bitmask;
                    end
                    BSC_INV: begin
                        next_rsp.wr_en = 1'b1;
                        next_rsp.wr_data = req_i.operand ^ bitmask;
                    end
                    BSC_TEST_AND_SET_OP: begin
                        next_sr[`BSC_SR_Z] = ~sel_bit;
                        next_sr[`BSC_SR_H] = 1'b1;
                        next_sr[`BSC_SR_N] = 1'b0;
                        next_rsp.wr_en = 1'b1;
                        next_rsp.wr_data = req_i.operand | bitmask;
                    end
                    BSC_SRCHB, BSC_SRCHF: begin
                        next_sr[`BSC_SR_V] = src_zero;
                        next_rsp.a_wr = ~src_zero;
                        next_rsp.a_data = {4'h0,
                            (req_i.op == BSC_SRCHB) ? hi_pos : lo_pos};
                    end
                    BSC_NORM: begin
                        next_sr[`BSC_SR_SYSTEM_MODE_FLAG] = 1'b0;
                    end
                    BSC_WIDE: begin
                        next_sr[`BSC_SR_WIDE] = 1'b1;
                        next_sr[`BSC_SR_BANK_HI] = 1'b0;
                    end
                    BSC_EI: begin
                        next_sr[`BSC_SR_MASK_HI:`BSC_SR_MASK_LO] =
                            req_i.has_imm ? req_i.imm3 : `BSC_MASK_DEF;
                    end
                    BSC_DI: begin
                        next_sr[`BSC_SR_MASK_HI:`BSC_SR_MASK_LO] = `BSC_MASK_ALL;
                    end
                    BSC_PUSH: begin
                        next_sp = stack_ptr_i - `BSC_STAT_BYTES;
                        next_rsp.mem_wr = 1'b1;
                        next_rsp.mem_addr = stack_ptr_i - `BSC_STAT_BYTES;
                        next_rsp.mem_data = sr & `BSC_SR_RSVD_MASK;
                    end
                    BSC_POP: begin
                        // Only path that can clear the width flag
                        next_sr = req_i.pop_word & `BSC_SR_RSVD_MASK;
                        next_sr[`BSC_SR_BANK_HI:`BSC_SR_BANK_LO] = bank_in;
                        next_sp = stack_ptr_i + `BSC_STAT_BYTES;
                        // Next fetch still uses the old area
                        next_fetch_system_mode_flag = sr[`BSC_SR_SYSTEM_MODE_FLAG];
                    end
                    BSC_TRAP, BSC_EXTI: begin
                        next_sr[`BSC_SR_SYSTEM_MODE_FLAG] = 1'b1;
                        next_sp = stack_ptr_i - (wide ? `BSC_FRAME_MAX
                                                       : `BSC_FRAME_MIN);
                        next_rsp.mem_wr = 1'b1;
                        next_rsp.mem_addr = next_sp;
                        next_rsp.mem_data = sr & `BSC_SR_RSVD_MASK;
                        next_rsp.mem_wr2 = 1'b1;
                        next_rsp.mem_addr2 = next_sp + `BSC_STAT_BYTES;
                        next_rsp.mem_data2 = wide ? req_i.next_pc
                                                  : {16'h0000, req_i.next_pc[15:0]};
                        next_rsp.jump = (req_i.op == BSC_TRAP);
                        next_rsp.jump_pc = `BSC_TRAP_BASE
                            + {25'h0000000, (req_i.has_imm ? req_i.imm3 : `BSC_TRAP_DEF),
                               4'h0};
                    end
                    default: begin
                        next_rsp.done = 1'b1;
                    end
                endcase
            end
        end else begin
            next_fetch_system_mode_flag = fetch_system_mode_flag ? sr[`BSC_SR_SYSTEM_MODE_FLAG] : sr[`BSC_SR_SYSTEM_MODE_FLAG];
        end
        next_sr[5] = 1'b0;
        next_sr[3] = 1'b0;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sr <= `BSC_SR_RESET;
            sp <= 32'h0000_0000;
            fetch_system_mode_flag <= 1'b1;
            rsp <= '0;
        end else begin
            sr <= next_sr;
            sp <= next_sp;
            fetch_system_mode_flag <= next_fetch_system_mode_flag;
            rsp <= next_rsp;
        end
    end

    assign rsp_o = rsp;
    assign stack_ptr_o = sp;
    assign status_o = sr;
    assign fetch_system_mode_flag_o = fetch_system_mode_flag;
endmodule

/* tb/bsc_chk_asserts.sv */
module bsc_chk
    import bsc_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        req_valid_i,
    input wire bsc_req_type req_i,
    input wire logic [31:0] stack_ptr_i,
    input wire bsc_rsp_type rsp_o,
    input wire logic [31:0] stack_ptr_o,
    input wire logic [15:0] status_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    logic        sys;
    bsc_op_type  op;
    logic [31:0] vec;
    assign sys = req_valid_i && status_o[15];
    assign op = req_i.op;
    assign vec = 32'h8000 + {25'h0, req_i.has_imm ? req_i.imm3 : 3'h7, 4'h0};
    a_idle_quiet: assert property (
        req_valid_i && op == BSC_IDLE |=> rsp_o.done && $stable(status_o))
        else $error("idle op changed state");
    a_norm_clears: assert property (sys && op == BSC_NORM |=> !status_o[15])
        else $error("normal entry kept system mode");
    a_wide_sets: assert property (sys && op == BSC_WIDE |=> status_o[11])
        else $error("wide op left width flag clear");
    a_mask_all: assert property (sys && op == BSC_DI |=> status_o[14:12] == 3'h7)
        else $error("mask level not 7");
    a_priv_refused: assert property (
        req_valid_i && !status_o[15] && op inside {[BSC_NORM:BSC_POP]}
        |=> rsp_o.priv_fault && $stable(status_o)) else $error("privileged op ran");
    a_push_frame: assert property (
        sys && op == BSC_PUSH |=> stack_ptr_o == $past(stack_ptr_i) - 32'h2
        && rsp_o.mem_addr == stack_ptr_o) else $error("push frame wrong");
    a_pop_step: assert property (
        sys && op == BSC_POP |=> stack_ptr_o == $past(stack_ptr_i) + 32'h2)
        else $error("pop step wrong");
    a_sys_entry: assert property (
        $rose(status_o[15]) |-> $past(req_valid_i) && $past(op) inside {BSC_TRAP, BSC_EXTI})
        else $error("system mode entered without trap");
    a_trap_vector: assert property (
        req_valid_i && op == BSC_TRAP |=> rsp_o.jump_pc == $past(vec))
        else $error("trap vector wrong");
    c_trap: cover property (req_valid_i && op == BSC_TRAP);
    c_fault: cover property (rsp_o.priv_fault);
    c_pop: cover property (sys && op == BSC_POP);
endmodule

bind bsc_core bsc_chk i_bsc_chk (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .req_valid_i(req_valid_i),
    .req_i      (req_i),
    .stack_ptr_i(stack_ptr_i),
    .rsp_o      (rsp_o),
    .stack_ptr_o(stack_ptr_o),
    .status_o   (status_o)
);

/* tb/test_bit_ops_and_status_control.sv */
`define CHK(a, b) begin \
    compares++; \
    if ((a) !== (b)) begin \
        n_fail++; \
        $display("unexpected at %0t: %h vs %h", $time, a, b); \
    end \
end

module test_bit_ops_and_status_control
    import bsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req_valid_i = 1'b0;
    bsc_req_type req_i = '0;
    bsc_req_type r;
    bsc_rsp_type rsp_o;
    logic [31:0] stack_ptr_i = '0;
    logic [31:0] stack_ptr_o;
    logic [31:0] sp;
    logic [15:0] status_o;
    logic [15:0] s;
    logic [15:0] m;
    logic [3:0]  k;
    logic        fetch_system_mode_flag_o;
    int          n_fail = 0;
    int          compares = 0;

    bsc_core i_bsc_core (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .req_valid_i (req_valid_i),
        .req_i       (req_i),
        .trap_kind_i (BSC_TRAP_SW),
        .stack_ptr_i (stack_ptr_i),
        .rsp_o       (rsp_o),
        .stack_ptr_o (stack_ptr_o),
        .status_o    (status_o),
        .fetch_system_mode_flag_o(fetch_system_mode_flag_o)
    );

    always #20 ref_clk_i = ~ref_clk_i;

    function automatic logic [15:0] fix(input logic [15:0] w);
        fix = w & 16'hFFD7;
        if (w[11])
            fix[10] = 1'b0;
    endfunction

    function automatic logic [15:0] bexp(input logic [15:0] v, input logic [3:0] n,
                                         input bsc_op_type o);
        bexp = v;
        bexp[n] = o == BSC_CLR ? 1'b0 : o == BSC_INV ? ~v[n] : 1'b1;
    endfunction

    function automatic logic [7:0] srch(input logic [15:0] v, input logic back);
        srch = 8'h00;
        for (int i = 0; i < 16; i++)
            if (v[back ? i : 15 - i])
                srch = 8'(back ? i : 15 - i);
    endfunction

    task automatic go;
        @(posedge ref_clk_i);
        req_i <= r;
        stack_ptr_i <= sp;
        req_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        req_valid_i <= 1'b0;
        #1;
        `CHK(rsp_o.done, 1'b1)
    endtask

    // Status can only be loaded through a pop, so every setup goes that way
    task automatic setsr(input logic [15:0] w);
        r = '0;
        r.op = BSC_POP;
        r.pop_word = w;
        go;
        s = fix(w);
        `CHK({status_o, stack_ptr_o}, {s, sp + 32'h2})
    endtask

    task automatic finish_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge ref_clk_i);
        n_fail++;
        finish_test;
    end

    initial begin
        void'($urandom(5));
        sp = 32'h100;
        r = '0;
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        `CHK({status_o, fetch_system_mode_flag_o}, {16'hF000, 1'b1})
        go;
        `CHK({rsp_o.wr_en, rsp_o.jump, status_o}, {2'b00, 16'hF000})
        for (int t = 0; t < 40; t++) begin
            setsr(16'h8000 | 16'($urandom) & 16'h77FF);
            r.op = bsc_op_type'(5'(2 + t % 5));
            r.operand = t < 2 ? {16{t[0]}} : 16'($urandom);
            r.bit_num = 4'($urandom);
            r.mem_form = t[1];
            k = r.mem_form ? {1'b0, r.bit_num[2:0]} : r.bit_num;
            m = r.mem_form ? 16'h00FF : 16'hFFFF;
            go;
            if (r.op inside {BSC_TEST, BSC_TEST_AND_SET_OP})
                s = {s[15:7], ~r.operand[k], s[5], 1'b1, s[3:2], 1'b0, s[0]};
            `CHK(status_o, s)
            if (r.op != BSC_TEST)
                `CHK(rsp_o.wr_data & m, bexp(r.operand, k, r.op) & m)
        end
        for (int z = 0; z < 2; z++) begin
            setsr(z ? 16'h8053 : 16'h8012);
            r.op = BSC_ZCF;
            go;
            s = z ? 16'h8050 : 16'h8011;
            `CHK(status_o, s)
        end
        $display("flag and bit tests end");
        for (int t = 0; t < 24; t++) begin
            r.op = t[0] ? BSC_SRCHB : BSC_SRCHF;
            r.operand = t < 2 ? 16'h1200 : t < 4 ? 16'h0000 : 16'($urandom) >> t[3:0];
            go;
            s[2] = r.operand == 16'h0000;
            `CHK({status_o, rsp_o.a_wr}, {s, ~s[2]})
            if (!s[2])
                `CHK(rsp_o.a_data, srch(r.operand, t[0]))
        end
        for (int j = 0; j < 10; j++) begin
            r.op = j == 1 ? BSC_DI : BSC_EI;
            r.has_imm = j > 1;
            r.imm3 = j > 1 ? 3'(j - 2) : 3'h5;
            go;
            s[14:12] = j == 1 ? 3'h7 : r.imm3 & {3{r.has_imm}};
            `CHK(status_o, s)
        end
        sp = 32'($urandom) & 32'h00FF_FFFE;
        r.op = BSC_PUSH;
        go;
        `CHK({stack_ptr_o, rsp_o.mem_addr, rsp_o.mem_data}, {sp - 32'h2, sp - 32'h2, s})
        r.op = BSC_WIDE;
        go;
        s[11] = 1'b1;
        `CHK(status_o, s)
        setsr(16'h8F00);
        setsr(16'h8000);
        setsr(16'h0000);
        `CHK(fetch_system_mode_flag_o, 1'b1)
        r.op = BSC_IDLE;
        go;
        `CHK(fetch_system_mode_flag_o, 1'b0)
        $display("mode and stack tests end");
        for (int w = 0; w < 2; w++) begin
            sp = 32'h100;
            r = '0;
            r.op = BSC_TRAP;
            r.has_imm = !w[0];
            r.imm3 = w ? 3'h2 : 3'h5;
            r.next_pc = w ? 32'h1234_5678 : 32'h8401;
            go;
            `CHK({status_o, stack_ptr_o, rsp_o.mem_data}, {s | 16'h8000, 32'h100 - 32'(4 + 2 * w), s})
            `CHK({rsp_o.mem_addr2, rsp_o.mem_data2}, {stack_ptr_o + 32'h2, r.next_pc})
            `CHK({rsp_o.jump, rsp_o.jump_pc}, {1'b1, w ? 32'h8070 : 32'h8050})
            s = s | 16'h8800;
            r.op = BSC_WIDE;
            go;
        end
        r.op = BSC_NORM;
        go;
        s[15] = 1'b0;
        `CHK(status_o, s)
        for (int o = 9; o < 15; o++) begin
            r.op = bsc_op_type'(5'(o));
            go;
            `CHK({rsp_o.priv_fault, status_o}, {1'b1, s})
        end
        r.op = BSC_EXTI;
        go;
        `CHK({rsp_o.jump, status_o[15]}, 2'b01)
        $display("trap and privilege tests end");
        finish_test;
    end
endmodule
